// ===== acp_ctrl.sv
// converter control port: start, busy, reset/calibration, power-down,
// reference enables and result output bus
// assumes all pins synchronous to ref_clk; analog core supplies the code
`timescale 1ns/1ns
// Function
// - top four result bits are driven outputs in every interface mode
// - busy rises at conversion start, falls once result is latched
// - busy falling edge marks new result ready
// - output bus below the top four bits enabled only while chip select and read are low
// - slave serial clock ignored while chip select is high
// - reset pin high holds device in reset, aborting any conversion
// - reset pin falling starts calibration, shown by a busy pulse
// - power-down finishes current conversion, then blocks starts, lowers power
// - start falling edge puts sample-hold in hold and starts conversion
// - both reference power-downs low: internal reference and buffer on
// - both reference power-downs high: reference and buffer off, external used
// - reference power-down high turns off the internal bandgap
// - buffer power-down high turns off the reference buffer
// - buffer on, bandgap off: external bandgap node level scaled up
// - interface mode 3 makes shared data pins a serial port
// - slave read unfinished at next result: data dropped, error pulsed
module acp_ctrl
   import acp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic conversion_start_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic reset_pin,
   input wire logic power_down_in,
   input wire logic ref_power_down,
   input wire logic buffer_power_down,
   input wire logic [1:0] mode,
   input wire logic word_sel_a0,
   input wire logic word_sel_a1,
   input wire logic clock_source_select,
   input wire logic sclk_in,
   input wire logic [RES_W-1:0] analog_code,
   output logic busy,
   output logic sample_hold,
   output logic low_power,
   output logic int_ref_on,
   output logic ref_buf_on,
   output logic bandgap_scaling,
   output logic [RES_W-1:0] data_out,
   output logic [RES_W-1:0] data_oe
);
   acp_state_type st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d, busy_run_q, busy_run_d;
   logic [RES_W-1:0] result_q, result_d;
   logic [RES_W-1:0] dout_q, dout_d;
   logic cnv_prev_q, busy_q, busy_d, hold_q, hold_d, done_q, done_d;
   logic pd_q, pd_d, iref_q, iref_d, ibuf_q, ibuf_d;
   logic cnv_fall, bus_en, ser_mode, master;
   logic ser_sdo, ser_sclk, ser_sync, ser_err;

   // parallel word placement for the three parallel modes
   function automatic logic [RES_W-1:0] par_word(input logic [1:0] m,
         input logic a0, input logic a1, input logic [RES_W-1:0] r);
      logic [RES_W-1:0] w;
      w = WORD_ZERO;
      unique case (m)
         MODE_PAR16: begin
            if (!a0) begin
               w[RES_W-1:2] = r[RES_W-1:2];
            end else begin
               w[3:2] = r[1:0];
            end
         end
         MODE_PAR8: begin
            if (!a0 && !a1) begin
               w[RES_W-1:10] = r[RES_W-1:10];
            end else if (!a0) begin
               w[RES_W-1:10] = r[9:2];
            end else if (!a1) begin
               w[11:10] = r[1:0];
            end else begin
               w[RES_W-1:16] = r[1:0];
            end
         end
         default: begin
            w = r;
         end
      endcase
      return w;
   endfunction

   // output enable mask per mode
   function automatic logic [RES_W-1:0] oe_mask(input logic [1:0] m,
         input logic en, input logic mst);
      logic [RES_W-1:0] o;
      o = OE_NONE;
      if (en) begin
         unique case (m)
            MODE_PAR18: o = OE_PAR18;
            MODE_PAR16: o = OE_PAR16;
            MODE_PAR8: o = OE_PAR8;
            MODE_SERIAL: o = mst ? (OE_SER_BASE | OE_SCLK) : OE_SER_BASE;
         endcase
      end
      return o;
   endfunction

   assign cnv_fall = cnv_prev_q && !conversion_start_n;
   assign ser_mode = (mode == MODE_SERIAL);
   assign master = !clock_source_select;
   // bus below the top four bits released while chip reset or reset pin hold
   assign bus_en = !cs_n && !rd_n && st_q != ST_HELD && !reset_pin;

   // conversion and calibration sequencer
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      result_d = result_q;
      busy_d = busy_q;
      hold_d = hold_q;
      done_d = 1'b0;
      busy_run_d = busy_q ? busy_run_q + CNT_W'(1) : '0;
      if (reset_pin) begin
         // abandon any conversion
         st_d = ST_HELD;
         cnt_d = '0;
         busy_d = 1'b0;
         hold_d = 1'b0;
      end else begin
         unique case (st_q)
            ST_HELD: begin
               // calibration announced by busy
               st_d = ST_CAL;
               cnt_d = CNT_W'(CAL_CYCLES - 1);
               busy_d = 1'b1;
            end
            ST_CAL: begin
               if (cnt_q == '0) begin
                  st_d = ST_IDLE;
                  busy_d = 1'b0;
               end else begin
                  cnt_d = cnt_q - CNT_W'(1);
               end
            end
            ST_IDLE: begin
               // starts refused under power-down
               if (cnv_fall && !power_down_in) begin
                  st_d = ST_CONV;
                  cnt_d = CNT_W'(CONV_CYCLES - 1);
                  busy_d = 1'b1;
                  hold_d = 1'b1;
               end
            end
            ST_CONV: begin
               if (cnt_q == '0) begin
                  // latch result on the same edge that busy falls as data-ready
                  st_d = ST_IDLE;
                  result_d = analog_code;
                  busy_d = 1'b0;
                  hold_d = 1'b0;
                  done_d = 1'b1;
               end else begin
                  cnt_d = cnt_q - CNT_W'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         result_q <= '0;
         busy_q <= 1'b0;
         hold_q <= 1'b0;
         done_q <= 1'b0;
         busy_run_q <= '0;
         cnv_prev_q <= 1'b1;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         result_q <= result_d;
         busy_q <= busy_d;
         hold_q <= hold_d;
         done_q <= done_d;
         busy_run_q <= busy_run_d;
         cnv_prev_q <= conversion_start_n;
      end
   end

   // power and reference controls
   always_comb begin
      // power drops only after a running conversion ends
      pd_d = power_down_in && st_q != ST_CONV;
      iref_d = !ref_power_down;
      ibuf_d = !buffer_power_down;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pd_q <= 1'b0;
         iref_q <= 1'b0;
         ibuf_q <= 1'b0;
      end else begin
         pd_q <= pd_d;
         iref_q <= iref_d;
         ibuf_q <= ibuf_d;
      end
   end

   acp_serial u_serial (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(done_d),
      .word(analog_code),
      .serial_mode(ser_mode),
      .master(master),
      .read_en(bus_en),
      .cs_n(cs_n),
      .sclk_in(sclk_in),
      .sdo(ser_sdo),
      .sclk_out(ser_sclk),
      .sync(ser_sync),
      .read_error(ser_err)
   );

   // output data word
   always_comb begin
      dout_d = par_word(mode, word_sel_a0, word_sel_a1, result_q);
      if (ser_mode) begin
         // shared pins carry the serial port
         dout_d[RES_W-1:ALWAYS_LSB] = result_q[RES_W-1:ALWAYS_LSB];
         dout_d[SDO_BIT] = ser_sdo;
         dout_d[SCLK_BIT] = ser_sclk;
         dout_d[SYNC_BIT] = ser_sync;
         dout_d[RDERR_BIT] = ser_err;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dout_q <= '0;
      end else begin
         dout_q <= dout_d;
      end
   end

   assign busy = busy_q;
   assign sample_hold = hold_q;
   assign low_power = pd_q;
   assign int_ref_on = iref_q;
   assign ref_buf_on = ibuf_q;
   assign bandgap_scaling = ibuf_q && !iref_q;
   assign data_out = dout_q;
   // top bits always driven; others only on read
   assign data_oe = oe_mask(mode, bus_en, master);

   AST_START_BUSY: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_IDLE && cnv_fall && !reset_pin && !power_down_in)
      |=> busy && sample_hold)
      else $error("start edge did not raise busy and hold");
   AST_CONV_LEN: assert property (@(posedge ref_clk) disable iff (rst)
      done_q |-> !busy && busy_run_q == CNT_W'(CONV_CYCLES))
      else $error("conversion length wrong");
   AST_DONE_FALL: assert property (@(posedge ref_clk) disable iff (rst)
      done_q |-> $fell(busy) && !sample_hold
      && result_q == $past(analog_code))
      else $error("result not latched at busy fall");
   AST_RESET_ABORT: assert property (@(posedge ref_clk) disable iff (rst)
      reset_pin |=> st_q == ST_HELD && !busy && !sample_hold)
      else $error("reset pin did not abort");
   AST_CAL_BUSY: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_HELD && !reset_pin) |=> busy && st_q == ST_CAL)
      else $error("calibration busy pulse missing");
   AST_PD_BLOCK: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_IDLE && power_down_in && !reset_pin) |=> !busy)
      else $error("conversion started in power-down");
   AST_ALWAYS_OUT: assert property (@(posedge ref_clk) disable iff (rst)
      data_oe[RES_W-1:ALWAYS_LSB] == ALWAYS_OE)
      else $error("top result bits not driven");
   AST_BUS_GATE: assert property (@(posedge ref_clk) disable iff (rst)
      (cs_n || rd_n || reset_pin) |-> data_oe[ALWAYS_LSB-1:0] == '0)
      else $error("bus driven without chip select and read");
   AST_REF_ON: assert property (@(posedge ref_clk) disable iff (rst)
      (!ref_power_down && !buffer_power_down) |=> int_ref_on && ref_buf_on)
      else $error("internal reference not enabled");
   AST_REF_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      (ref_power_down && buffer_power_down) |=> !int_ref_on && !ref_buf_on)
      else $error("internal reference not disabled");

   COV_CONV: cover property (@(posedge ref_clk) disable iff (rst)
      $rose(busy) ##[1:60] done_q);
   COV_CAL: cover property (@(posedge ref_clk) disable iff (rst)
      $fell(reset_pin) ##1 busy);
   COV_SER_READ: cover property (@(posedge ref_clk) disable iff (rst)
      ser_mode && bus_en && ser_sync);
   COV_RDERR: cover property (@(posedge ref_clk) disable iff (rst) ser_err);
endmodule

// ===== acp_ctrl_bench.sv
// testbench for the converter control port with a host model
// assumes acp_pkg and acp_host are compiled first
`timescale 1ns/1ns
module acp_ctrl_bench
   import acp_pkg::*;
;
   logic ref_clk, rst, reset_pin, power_down_in, clock_source_select;
   logic word_sel_a0, word_sel_a1, go, force_go, rd_req, sclk_req;
   logic [1:0] mode, ref_sel;
   logic [RES_W-1:0] analog_code, data_out, data_oe;
   logic conversion_start_n, cs_n, rd_n, sclk_in;
   logic ref_power_down, buffer_power_down, busy, sample_hold;
   logic low_power, int_ref_on, ref_buf_on, bandgap_scaling;
   int n_mismatch, tests_run;

   acp_ctrl uut (.ref_clk(ref_clk), .rst(rst),
      .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n),
      .reset_pin(reset_pin), .power_down_in(power_down_in),
      .ref_power_down(ref_power_down),
      .buffer_power_down(buffer_power_down), .mode(mode),
      .word_sel_a0(word_sel_a0), .word_sel_a1(word_sel_a1),
      .clock_source_select(clock_source_select), .sclk_in(sclk_in),
      .analog_code(analog_code), .busy(busy), .sample_hold(sample_hold),
      .low_power(low_power), .int_ref_on(int_ref_on),
      .ref_buf_on(ref_buf_on), .bandgap_scaling(bandgap_scaling),
      .data_out(data_out), .data_oe(data_oe));

   acp_host host (.ref_clk(ref_clk), .rst(rst), .busy(busy),
      .reset_pin(reset_pin), .power_down_in(power_down_in), .go(go),
      .force_go(force_go), .rd_req(rd_req), .sclk_req(sclk_req),
      .ref_sel(ref_sel), .conversion_start_n(conversion_start_n),
      .cs_n(cs_n), .rd_n(rd_n), .sclk_in(sclk_in),
      .ref_power_down(ref_power_down),
      .buffer_power_down(buffer_power_down));

   always #5 ref_clk = ~ref_clk;

   task wrap_up;
      $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // counts cycles busy stays high, starting at a negedge where it is high
   task busy_len(output int n);
      n = 0;
      while (busy === 1'b1 && n < 300) begin
         n++;
         @(negedge ref_clk);
      end
   endtask

   task start_conv(input logic [RES_W-1:0] code);
      @(posedge ref_clk);
      analog_code <= code;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task sclk_pulses(input int k);
      repeat (k) begin
         @(posedge ref_clk);
         sclk_req <= 1'b1;
         cyc(2);
         sclk_req <= 1'b0;
         cyc(2);
      end
   endtask

   task t_conv(input logic [RES_W-1:0] code,
      input logic [RES_W-1:0] want);
      int n;
      start_conv(code);
      chk({17'h0, busy}, 18'h00001);
      chk({17'h0, sample_hold}, 18'h00001);
      busy_len(n);
      chk(n[RES_W-1:0], CONV_CYCLES[RES_W-1:0]);
      chk({17'h0, sample_hold}, 18'h00000);
      @(negedge ref_clk);
      chk(data_out, want);
   endtask

   // word and byte placement in the narrow parallel modes
   task t_words;
      logic [RES_W-1:0] exp [6];
      logic [3:0] sel [6];
      exp = '{18'h3A5C4, 18'h0000C, 18'h3A400, 18'h1C400, 18'h00C00,
         18'h30000};
      sel = '{4'h4, 4'h5, 4'h8, 4'hA, 4'h9, 4'hB};
      t_conv(18'h3A5C7, 18'h3A5C7);
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         {mode, word_sel_a1, word_sel_a0} <= sel[i];
         cyc(1);
         @(negedge ref_clk);
         chk(data_out, exp[i]);
      end
      @(posedge ref_clk);
      {mode, word_sel_a1, word_sel_a0} <= 4'h0;
   endtask

   task t_oe;
      logic [RES_W-1:0] exp [4];
      exp = '{OE_PAR18, OE_PAR16, OE_PAR8, OE_SER_BASE};
      for (int m = 0; m < 4; m++) begin
         @(posedge ref_clk);
         mode <= m[1:0];
         cyc(1);
         @(negedge ref_clk);
         chk(data_oe, exp[m]);
      end
      @(posedge ref_clk);
      clock_source_select <= 1'b0;
      cyc(1);
      @(negedge ref_clk);
      chk(data_oe, OE_SER_BASE | OE_SCLK);
      @(posedge ref_clk);
      rd_req <= 1'b0;
      cyc(1);
      @(negedge ref_clk);
      chk(data_oe, OE_NONE);
      @(posedge ref_clk);
      mode <= MODE_PAR18;
      clock_source_select <= 1'b1;
      rd_req <= 1'b1;
   endtask

   task t_reset;
      int n;
      start_conv(18'h15A5A);
      cyc(10);
      reset_pin <= 1'b1;
      cyc(2);
      @(negedge ref_clk);
      chk({17'h0, busy}, 18'h00000);
      chk(data_oe, OE_NONE);
      @(posedge ref_clk);
      reset_pin <= 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 5) begin
         @(negedge ref_clk);
         n++;
      end
      busy_len(n);
      chk(n[RES_W-1:0], CAL_CYCLES[RES_W-1:0]);
   endtask

   task t_pd;
      int n;
      start_conv(18'h0F0F0);
      cyc(5);
      power_down_in <= 1'b1;
      cyc(1);
      @(negedge ref_clk);
      chk({17'h0, low_power}, 18'h00000);
      busy_len(n);
      @(negedge ref_clk);
      chk(data_out, 18'h0F0F0);
      chk({17'h0, low_power}, 18'h00001);
      @(posedge ref_clk);
      force_go <= 1'b1;
      @(posedge ref_clk);
      force_go <= 1'b0;
      cyc(3);
      @(negedge ref_clk);
      chk({17'h0, busy}, 18'h00000);
      @(posedge ref_clk);
      power_down_in <= 1'b0;
      cyc(2);
      @(negedge ref_clk);
      chk({17'h0, low_power}, 18'h00000);
   endtask

   task t_ref;
      logic rp, bp;
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         ref_sel <= i[1:0];
         rp = i[0];
         bp = i[0] & i[1];
         cyc(3);
         @(negedge ref_clk);
         chk({17'h0, int_ref_on}, {17'h0, !rp});
         chk({17'h0, ref_buf_on}, {17'h0, !bp});
         chk({17'h0, bandgap_scaling}, {17'h0, rp && !bp});
      end
   endtask

   task t_serial;
      int n;
      logic seen;
      @(posedge ref_clk);
      mode <= MODE_SERIAL;
      rd_req <= 1'b0;
      t_conv(18'h20000, 18'h20400);
      sclk_pulses(4);
      rd_req <= 1'b1;
      cyc(3);
      @(negedge ref_clk);
      chk({17'h0, data_out[SDO_BIT]}, 18'h00001);
      sclk_pulses(3);
      start_conv(18'h1FFFF);
      busy_len(n);
      seen = 1'b0;
      repeat (8) begin
         @(negedge ref_clk);
         if (data_out[RDERR_BIT] === 1'b1)
            seen = 1'b1;
      end
      chk({17'h0, seen}, 18'h00001);
   endtask

   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      {reset_pin, power_down_in, word_sel_a0, word_sel_a1} = 4'h0;
      {go, force_go, sclk_req} = 3'h0;
      clock_source_select = 1'b1;
      rd_req = 1'b1;
      mode = MODE_PAR18;
      ref_sel = 2'h0;
      analog_code = WORD_ZERO;
      n_mismatch = 0;
      tests_run = 0;
      cyc(10);
      rst <= 1'b0;
      t_conv(18'h2A5C3, 18'h2A5C3);
      t_conv(18'h15A3C, 18'h15A3C);
      t_words();
      t_oe();
      t_reset();
      t_pd();
      t_ref();
      t_serial();
      wrap_up();
   end

   initial begin
      #100000;
      n_mismatch++;
      wrap_up();
   end
endmodule

// ===== acp_host.sv
// host model: issues conversion starts, reads, serial clock and reference
// pins on request from the bench
// assumes requests change just after ref_clk rising edges
`timescale 1ns/1ns
module acp_host
   import acp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic busy,
   input wire logic reset_pin,
   input wire logic power_down_in,
   input wire logic go,
   input wire logic force_go,
   input wire logic rd_req,
   input wire logic sclk_req,
   input wire logic [1:0] ref_sel,
   output logic conversion_start_n,
   output logic cs_n,
   output logic rd_n,
   output logic sclk_in,
   output logic ref_power_down,
   output logic buffer_power_down
);
   logic start_n_d;
   logic sel_n_d;
   logic sclk_d;

   always_comb begin
      // go starts only while idle, out of reset and powered up; force_go starts regardless
      start_n_d = !((go && !busy && !reset_pin && !power_down_in)
         || force_go);
      sel_n_d = !rd_req;
      sclk_d = sclk_req;
      ref_power_down = ref_sel[0];
      // buffer stays on whenever the internal reference is in use
      buffer_power_down = ref_sel[1] && ref_sel[0];
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conversion_start_n <= 1'b1;
         cs_n <= 1'b1;
         rd_n <= 1'b1;
         sclk_in <= 1'b0;
      end else begin
         conversion_start_n <= start_n_d;
         cs_n <= sel_n_d;
         rd_n <= sel_n_d;
         sclk_in <= sclk_d;
      end
   end
endmodule

// ===== acp_pkg.sv
// constants shared by the converter control port
// assumes a single 100 MHz clock feeding every module
package acp_pkg;
   localparam int RES_W = 18;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_TIME_NS = 500;
   localparam int CAL_TIME_NS = 1000;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam int BITCNT_W = 5;
   localparam int SCLK_DIV = 4;
   localparam int DIV_W = 3;
   localparam logic [1:0] MODE_PAR18 = 2'h0;
   localparam logic [1:0] MODE_PAR16 = 2'h1;
   localparam logic [1:0] MODE_PAR8 = 2'h2;
   localparam logic [1:0] MODE_SERIAL = 2'h3;
   localparam int SDO_BIT = 10;
   localparam int SCLK_BIT = 11;
   localparam int SYNC_BIT = 12;
   localparam int RDERR_BIT = 13;
   localparam int ALWAYS_LSB = 14;
   localparam logic [3:0] ALWAYS_OE = 4'hF;
   localparam logic [RES_W-1:0] OE_PAR18 = 18'h3FFFF;
   localparam logic [RES_W-1:0] OE_PAR16 = 18'h3FFFC;
   localparam logic [RES_W-1:0] OE_PAR8 = 18'h3FC00;
   localparam logic [RES_W-1:0] OE_SER_BASE = 18'h3F400;
   localparam logic [RES_W-1:0] OE_SCLK = 18'h00800;
   localparam logic [RES_W-1:0] OE_NONE = 18'h3C000;
   localparam logic [RES_W-1:0] WORD_ZERO = 18'h00000;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONV,
      ST_CAL,
      ST_HELD
   } acp_state_type;
endpackage

// ===== acp_serial.sv
// serial result shifter, master clock divider and incomplete-read flag
// assumes sclk_in and cs_n are synchronous to ref_clk
`timescale 1ns/1ns
module acp_serial
   import acp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [RES_W-1:0] word,
   input wire logic serial_mode,
   input wire logic master,
   input wire logic read_en,
   input wire logic cs_n,
   input wire logic sclk_in,
   output logic sdo,
   output logic sclk_out,
   output logic sync,
   output logic read_error
);
   logic [RES_W-1:0] sh_q, sh_d;
   logic [BITCNT_W-1:0] cnt_q, cnt_d;
   logic [DIV_W-1:0] div_q, div_d;
   logic prev_q, prev_d, sclk_q, sclk_d, err_q, err_d;
   logic gated, started, shift;

   always_comb begin
      gated = serial_mode && !master && !cs_n;
      started = (cnt_q != BITCNT_W'(RES_W)) && (cnt_q != '0);
      sh_d = sh_q;
      cnt_d = cnt_q;
      div_d = div_q;
      sclk_d = sclk_q;
      err_d = 1'b0;
      shift = 1'b0;
      // slave clock only seen while chip select is low
      prev_d = gated ? sclk_in : 1'b1;
      if (gated && sclk_in && !prev_q && cnt_q != '0) begin
         shift = 1'b1;
      end
      if (serial_mode && master && read_en && cnt_q != '0) begin
         if (div_q == DIV_W'(SCLK_DIV - 1)) begin
            div_d = '0;
            sclk_d = !sclk_q;
            shift = sclk_q;
         end else begin
            div_d = div_q + DIV_W'(1);
         end
      end else begin
         div_d = '0;
         sclk_d = 1'b0;
      end
      if (shift) begin
         sh_d = {sh_q[RES_W-2:0], 1'b0};
         cnt_d = cnt_q - BITCNT_W'(1);
      end
      if (load) begin
         sh_d = word;
         cnt_d = BITCNT_W'(RES_W);
         // unfinished slave read loses its word
         err_d = started && serial_mode && !master;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sh_q <= '0;
         cnt_q <= '0;
         div_q <= '0;
         prev_q <= 1'b1;
         sclk_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         div_q <= div_d;
         prev_q <= prev_d;
         sclk_q <= sclk_d;
         err_q <= err_d;
      end
   end

   assign sdo = sh_q[RES_W-1];
   assign sclk_out = sclk_q;
   assign sync = serial_mode && master && read_en && cnt_q != '0;
   assign read_error = err_q;

   AST_SCLK_GATED: assert property (@(posedge ref_clk) disable iff (rst)
      (cs_n && !master && !load) |=> (cnt_q == $past(cnt_q)))
      else $error("slave clock shifted while deselected");
   AST_RDERR_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
      (load && started && serial_mode && !master) |=> read_error ##1 !read_error)
      else $error("incomplete read flag not pulsed");
endmodule
